/* zone_lookup.sv */
/*
  Combinational zone search: returns the zone whose range holds the setpoint.
  Assumes zone tops ascend with zone number and count never exceeds NZONES.
*/
`timescale 1ns/1ps
module zone_lookup #(
  parameter int NZONES = 10,
  parameter int SETP_W = 32,
  parameter int ZIDX_W = 4
) (
  input wire logic [SETP_W-1:0] setp_i, // setpoint
  input wire logic [NZONES*SETP_W-1:0] tops_i, // zone upper limits, zone 1 lowest
  input wire logic [ZIDX_W-1:0] count_i, // zones in use
  output logic [ZIDX_W-1:0] zone_o // matching zone 1..count, 0 if none used
);
  // above every top the last used zone applies; walk downward so the
  // lowest matching zone is the one left standing
  always_comb begin
    zone_o = count_i;
    for (int i = NZONES - 1; i >= 0; i--) begin
      // bottom of zone one is zero, each top is the next bottom
      if ((ZIDX_W'(i) < count_i) && (setp_i <= tops_i[i*SETP_W +: SETP_W])) begin
        zone_o = ZIDX_W'(i + 1);
      end
    end
  end
endmodule

/* zone_parameter_selector.sv */
/*
  Zone tuning selector: zone table, active control settings, AXI4-Lite slave.
  Assumes AXI4-Lite master on clk_sys_i; outputs feed the control loop,
  heater stage, relays and analog outputs.
*/
`timescale 1ns/1ps
module zone_parameter_selector #(
  parameter int NZONES = zone_pkg::ZONES_MAX
) (
  input wire logic clk_sys_i, // 40 MHz system clock
  input wire logic reset_i, // async reset, active high
  input wire logic [zone_pkg::ADDR_W-1:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // byte enables
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [zone_pkg::ADDR_W-1:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  output logic zone_tuning_o, // zone tuning mode active
  output logic [zone_pkg::ZIDX_W-1:0] active_zone_o, // loaded zone, 0 none
  output logic [zone_pkg::P_W-1:0] prop_o, // active P, thousandths
  output logic [zone_pkg::I_W-1:0] integ_o, // active I, 0 off
  output logic [zone_pkg::D_W-1:0] deriv_o, // active D, 0 off
  output logic [zone_pkg::MOUT_W-1:0] man_out_o, // manual output, 0.01 %
  output logic [zone_pkg::RNG_W-1:0] heater_range_o, // range code, 0 off
  output logic [zone_pkg::RNG_W-1:0] man_scale_o, // full-scale current decade
  output logic relay_low_o, // low relay drive
  output logic relay_low_zone_o, // low relay under zone control
  output logic relay_high_o, // high relay drive
  output logic relay_high_zone_o, // high relay under zone control
  output logic [zone_pkg::AO_W-1:0] aout1_o, // analog 1 value, 0.01 %
  output logic aout1_zone_o, // analog 1 under zone control
  output logic [zone_pkg::AO_W-1:0] aout2_o, // analog 2 value, 0.01 %
  output logic aout2_zone_o // analog 2 under zone control
);
  import zone_pkg::*;

  localparam logic [6:0] BLK_ZEND = 7'(BLK_ZONE0 + NZONES); // first block past table

  // table depth must fit the zone number field and the address window
  if (NZONES < 1 || NZONES > ZONES_MAX) begin : g_bad_depth
    $error("NZONES out of range");
  end

  // bus channel state
  logic aw_have_r; // write address held
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_have_r; // write data held
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // control state
  ctl_state_t st_r, st_nxt;
  logic [3:0] zcfg_r; // zone-mode enables: low, high relay, ao1, ao2
  logic [1:0] bip_r; // analog outputs bipolar
  logic [ZIDX_W-1:0] cnt_r; // zones in use
  logic [SETP_W-1:0] setp_r;
  logic pend_r; // setpoint change awaiting zone check
  logic [ZIDX_W-1:0] cur_zone_r; // zone last loaded
  logic reject_r; // sticky: a write was refused

  // zone table
  logic [SETP_W-1:0] zt_top [NZONES];
  logic [P_W-1:0] zt_p [NZONES];
  logic [I_W-1:0] zt_i [NZONES];
  logic [D_W-1:0] zt_d [NZONES];
  logic [MOUT_W-1:0] zt_mout [NZONES];
  logic [RNG_W-1:0] zt_rng [NZONES];
  logic [1:0] zt_rly [NZONES];
  logic [AO_W-1:0] zt_ao1 [NZONES];
  logic [AO_W-1:0] zt_ao2 [NZONES];

  // active control settings
  logic [P_W-1:0] act_p_r;
  logic [I_W-1:0] act_i_r;
  logic [D_W-1:0] act_d_r;
  logic [MOUT_W-1:0] act_mout_r;
  logic [RNG_W-1:0] act_rng_r;
  logic [1:0] act_rly_r;
  logic [AO_W-1:0] act_ao1_r;
  logic [AO_W-1:0] act_ao2_r;

  // address class, used for both read and write decode
  function automatic addr_kind_t kind_of(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'h0) begin
      return AK_NONE;
    end else if (a == OFS_CTRL) begin
      return AK_CTRL;
    end else if (a == OFS_SETP) begin
      return AK_SETP;
    end else if (a == OFS_STAT) begin
      return AK_STAT;
    end else if (a[11:5] == BLK_ACT && a[4:2] != F_TOP) begin
      return AK_ACT;
    end else if (a[11:5] >= BLK_ZONE0 && a[11:5] < BLK_ZEND) begin
      return AK_ZONE;
    end else begin
      return AK_NONE;
    end
  endfunction

  function automatic logic [ZIDX_W-1:0] zone_of(input logic [ADDR_W-1:0] a);
    return ZIDX_W'(a[11:5] - BLK_ZONE0);
  endfunction

  // packs one field of a settings set into a bus word
  function automatic logic [31:0] pack(input logic [2:0] f, input logic [SETP_W-1:0] top,
      input logic [P_W-1:0] p, input logic [I_W-1:0] i, input logic [D_W-1:0] d,
      input logic [MOUT_W-1:0] m, input logic [RNG_W-1:0] r, input logic [1:0] rly,
      input logic [AO_W-1:0] a1, input logic [AO_W-1:0] a2);
    case (f)
      F_TOP: return top;
      F_P: return 32'(p);
      F_I: return 32'(i);
      F_D: return 32'(d);
      F_MOUT: return 32'(m);
      F_RNG: return 32'(r);
      F_RLY: return 32'(rly);
      default: return {a2, a1};
    endcase
  endfunction

  // register read-back, also the base for byte-lane merges
  function automatic logic [31:0] regval(input logic [ADDR_W-1:0] a);
    logic [ZIDX_W-1:0] z;
    z = zone_of(a);
    case (kind_of(a))
      AK_CTRL: return {20'h0, cnt_r, bip_r, zcfg_r,
                       (st_r == ST_ZONE) ? MODE_ZONE : (st_r == ST_OPEN) ? MODE_OPEN : MODE_PID};
      AK_SETP: return setp_r;
      AK_STAT: return {26'h0, reject_r, (st_r == ST_ZONE), cur_zone_r};
      AK_ACT: return pack(a[4:2], '0, act_p_r, act_i_r, act_d_r, act_mout_r, act_rng_r,
                          act_rly_r, act_ao1_r, act_ao2_r);
      AK_ZONE: return pack(a[4:2], zt_top[z], zt_p[z], zt_i[z], zt_d[z], zt_mout[z],
                           zt_rng[z], zt_rly[z], zt_ao1[z], zt_ao2[z]);
      default: return 32'h0;
    endcase
  endfunction

  // analog limit depends on the output's polarity
  function automatic logic ao_ok(input logic signed [AO_W-1:0] x, input logic bip);
    return bip ? (x >= -AO_MAX && x <= AO_MAX) : (x >= 16'sh0000 && x <= AO_MAX);
  endfunction

  // clamp used when loading, in case polarity changed after programming
  function automatic logic [AO_W-1:0] ao_fit(input logic signed [AO_W-1:0] x,
      input logic bip);
    return (!bip && x < 16'sh0000) ? 16'h0000 : x;
  endfunction

  // value check for a settings field
  function automatic logic field_ok(input logic [2:0] f, input logic [31:0] v);
    case (f)
      F_P: return v >= 32'(P_MIN) && v <= 32'(P_MAX);
      F_I: return v <= 32'(I_MAX);
      F_D: return v <= 32'(D_MAX);
      F_MOUT: return v <= 32'(MOUT_MAX); // percent only
      F_RNG: return v <= 32'(RNG_MAX);
      F_AO: return ao_ok(v[15:0], bip_r[0]) && ao_ok(v[31:16], bip_r[1]);
      default: return 1'b1;
    endcase
  endfunction

  // write decode and merge of byte lanes
  addr_kind_t wkind;
  logic [2:0] wfield;
  logic [ZIDX_W-1:0] wzone;
  logic [31:0] wmask, wv;
  logic do_wr, wok, wr_en;
  always_comb begin
    wkind = kind_of(aw_addr_r);
    wfield = aw_addr_r[4:2];
    wzone = zone_of(aw_addr_r);
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{w_strb_r[b]}};
    end
    wv = (regval(aw_addr_r) & ~wmask) | (w_data_r & wmask);
    do_wr = aw_have_r && w_have_r && !bvalid_r;
    if (wkind == AK_CTRL) begin
      // count past the table depth would leave gaps
      wok = (wv[CB_MODE +: 2] != 2'h3) && (wv[CB_CNT +: 4] <= 4'(NZONES));
    end else if (wkind == AK_ACT || wkind == AK_ZONE) begin
      wok = field_ok(wfield, wv);
    end else begin
      wok = (wkind != AK_NONE);
    end
    wr_en = do_wr && wok;
  end

  // write channels: address and data taken in either order
  assign s_axi_awready_o = !aw_have_r;
  assign s_axi_wready_o = !w_have_r;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else begin
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (s_axi_awvalid_i && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
    end
  end

  // write response: refused values answer slverr and are not stored
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wkind == AK_NONE) ? RESP_DECERR : wok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // read channel: one word per request, answered the next cycle
  assign s_axi_arready_o = !rvalid_r;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= regval(s_axi_araddr_i);
      rresp_r <= (kind_of(s_axi_araddr_i) == AK_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // sticky reject flag; a new refusal wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reject_r <= 1'b0;
    end else if (do_wr && !wok && wkind != AK_NONE) begin
      reject_r <= 1'b1;
    end else if (do_wr && wkind == AK_STAT && w_data_r[SB_REJECT] && w_strb_r[0]) begin
      reject_r <= 1'b0;
    end
  end

  // control mode
  always_comb begin
    st_nxt = st_r;
    if (wr_en && wkind == AK_CTRL) begin
      case (wv[CB_MODE +: 2])
        MODE_ZONE: st_nxt = ST_ZONE;
        MODE_PID: st_nxt = ST_PID; // leaves zone tuning
        default: st_nxt = ST_OPEN;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= ST_PID;
      zcfg_r <= 4'h0;
      bip_r <= 2'h0;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (wr_en && wkind == AK_CTRL) begin
        zcfg_r <= wv[CB_ZCFG +: 4];
        bip_r <= wv[CB_BIP +: 2];
        cnt_r <= wv[CB_CNT +: 4];
      end
    end
  end

  // zone search on the current setpoint
  logic [NZONES*SETP_W-1:0] tops_flat;
  logic [ZIDX_W-1:0] hit_zone, hit_idx;
  logic enter_zone, load;
  for (genvar g = 0; g < NZONES; g++) begin : g_tops
    assign tops_flat[g*SETP_W +: SETP_W] = zt_top[g];
  end
  zone_lookup #(.NZONES(NZONES), .SETP_W(SETP_W), .ZIDX_W(ZIDX_W)) u_lookup (
    .setp_i(setp_r),
    .tops_i(tops_flat),
    .count_i(cnt_r),
    .zone_o(hit_zone)
  );
  assign hit_idx = hit_zone - 4'h1;
  assign enter_zone = (st_nxt == ST_ZONE) && (st_r != ST_ZONE);
  // only a setpoint change or mode entry triggers a load, never table edits
  assign load = (st_r == ST_ZONE) && pend_r && (cnt_r != '0)
              && (hit_zone != cur_zone_r);

  // setpoint and pending check
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      setp_r <= '0;
      pend_r <= 1'b0;
    end else begin
      if (wr_en && wkind == AK_SETP) begin
        setp_r <= wv;
      end
      pend_r <= (wr_en && wkind == AK_SETP) || enter_zone;
    end
  end

  // loaded zone; cleared on mode entry so the first check loads whenever zones are in use
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cur_zone_r <= '0;
    end else if (st_nxt != ST_ZONE || enter_zone) begin
      cur_zone_r <= '0;
    end else if (load) begin
      cur_zone_r <= hit_zone;
    end
  end

  // zone table writes; they never touch the active set directly
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int z = 0; z < NZONES; z++) begin
        zt_top[z] <= '0;
        zt_p[z] <= P_RST;
        zt_i[z] <= I_RST;
        zt_d[z] <= '0;
        zt_mout[z] <= '0;
        zt_rng[z] <= '0;
        zt_rly[z] <= 2'h0;
        zt_ao1[z] <= '0;
        zt_ao2[z] <= '0;
      end
    end else if (wr_en && wkind == AK_ZONE) begin
      case (wfield)
        F_TOP: zt_top[wzone] <= wv;
        F_P: zt_p[wzone] <= wv[P_W-1:0];
        F_I: zt_i[wzone] <= wv[I_W-1:0];
        F_D: zt_d[wzone] <= wv[D_W-1:0];
        F_MOUT: zt_mout[wzone] <= wv[MOUT_W-1:0];
        F_RNG: zt_rng[wzone] <= wv[RNG_W-1:0];
        F_RLY: zt_rly[wzone] <= wv[1:0];
        default: begin
          zt_ao1[wzone] <= wv[15:0];
          zt_ao2[wzone] <= wv[31:16];
        end
      endcase
    end
  end

  // active settings: zone load first, a manual write in the same cycle wins
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      act_p_r <= P_RST;
      act_i_r <= I_RST;
      act_d_r <= '0;
      act_mout_r <= '0;
      act_rng_r <= '0;
      act_rly_r <= 2'h0;
      act_ao1_r <= '0;
      act_ao2_r <= '0;
    end else begin
      if (load) begin
        act_p_r <= zt_p[hit_idx];
        act_i_r <= zt_i[hit_idx];
        act_d_r <= zt_d[hit_idx];
        act_mout_r <= zt_mout[hit_idx];
        act_rng_r <= zt_rng[hit_idx];
        act_rly_r <= zt_rly[hit_idx];
        act_ao1_r <= ao_fit(zt_ao1[hit_idx], bip_r[0]);
        act_ao2_r <= ao_fit(zt_ao2[hit_idx], bip_r[1]);
      end
      if (wr_en && wkind == AK_ACT) begin
        // manual edit, held until the setpoint leaves the zone
        case (wfield)
          F_P: act_p_r <= wv[P_W-1:0];
          F_I: act_i_r <= wv[I_W-1:0];
          F_D: act_d_r <= wv[D_W-1:0];
          F_MOUT: act_mout_r <= wv[MOUT_W-1:0];
          F_RNG: act_rng_r <= wv[RNG_W-1:0];
          F_RLY: act_rly_r <= wv[1:0];
          default: begin
            act_ao1_r <= wv[15:0];
            act_ao2_r <= wv[31:16];
          end
        endcase
      end
    end
  end

  // relay and analog drive, gated by each output's zone-mode enable
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      relay_low_o <= 1'b0;
      relay_high_o <= 1'b0;
      aout1_o <= '0;
      aout2_o <= '0;
    end else begin
      relay_low_o <= zcfg_r[0] & act_rly_r[0];
      relay_high_o <= zcfg_r[1] & act_rly_r[1];
      aout1_o <= zcfg_r[2] ? act_ao1_r : '0;
      aout2_o <= zcfg_r[3] ? act_ao2_r : '0;
    end
  end

  assign relay_low_zone_o = zcfg_r[0];
  assign relay_high_zone_o = zcfg_r[1];
  assign aout1_zone_o = zcfg_r[2];
  assign aout2_zone_o = zcfg_r[3];
  assign zone_tuning_o = (st_r == ST_ZONE);
  assign active_zone_o = cur_zone_r;
  assign prop_o = act_p_r;
  assign integ_o = act_i_r;
  assign deriv_o = act_d_r;
  assign man_out_o = act_mout_r;
  assign heater_range_o = act_rng_r;
  // multiplier comes from the range alone, no register of its own
  assign man_scale_o = (act_rng_r == '0) ? '0 : act_rng_r - 4'h1;
endmodule

/* zone_parameter_selector_tb_top.sv */
/* bench for the zone selector: AXI4-Lite tasks and zone sequences.
   assumes zone_pkg and zone_sel_props are compiled first */
`timescale 1ns/1ps
module zone_parameter_selector_tb_top;
  import zone_pkg::*;
  logic clk_sys_i = 0, reset_i = 1;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i, active_zone_o, heater_range_o, man_scale_o;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic zone_tuning_o, relay_low_o, relay_low_zone_o, relay_high_o, relay_high_zone_o;
  logic aout1_zone_o, aout2_zone_o;
  logic [19:0] prop_o;
  logic [13:0] integ_o, man_out_o;
  logic [11:0] deriv_o;
  logic [15:0] aout1_o, aout2_o;
  int fail_count = 0, checked = 0;
  zone_parameter_selector u_zone_parameter_selector (.*);
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  task results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // a hung handshake counts as a mismatch and ends the run
  task lost(int n);
    if (n >= 50) begin
      fail_count++;
      results();
    end
  endtask
  function logic [11:0] za(int z, int f);
    return 12'(256 + 32 * z + 4 * f);
  endfunction
  // address and data offered together, each dropped once taken
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
    int n = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (s_axi_bvalid_o !== 1 && n < 50);
    s_axi_bready_i <= 0;
    chk("bresp", r, s_axi_bresp_o);
    lost(n);
    // one edge between calls, so ready is never dropped and raised in one step
    tick(1);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] r = RESP_OKAY);
    int n = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (s_axi_rvalid_o !== 1 && n < 50);
    s_axi_rready_i <= 0;
    chk("rdata", e, s_axi_rdata_o);
    chk("rresp", r, s_axi_rresp_o);
    lost(n);
    tick(1);
  endtask
  // load lands a cycle after the write, relays one more
  task zs(logic [3:0] z, logic [19:0] p);
    tick(3);
    chk("zone", z, active_zone_o);
    chk("prop", p, prop_o);
  endtask
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 0;
    s_axi_awaddr_i = 0;
    s_axi_araddr_i = 0;
    s_axi_wdata_i = 0;
    s_axi_wstrb_i = 4'hf;
    tick(12);
    reset_i <= 0;
    tick(1);
    rd(OFS_CTRL, 0);
    rd(12'h044, P_RST);
    rd(12'h048, I_RST);
    rd(12'hffc, 0, RESP_DECERR);
    wr(za(0, 2), I_MAX + 1, RESP_SLVERR);
    wr(za(0, 2), 0);
    wr(za(0, 3), D_MAX + 1, RESP_SLVERR);
    wr(za(0, 4), MOUT_MAX + 1, RESP_SLVERR);
    wr(za(0, 1), 0, RESP_SLVERR);
    wr(za(0, 1), P_MAX + 1, RESP_SLVERR);
    wr(za(0, 7), 32'hffff, RESP_SLVERR);
    wr(OFS_CTRL, 32'h3, RESP_SLVERR);
    rd(OFS_STAT, 32'h20);
    // sticky reject flag clears on a one written to it
    wr(OFS_STAT, 32'h20);
    rd(OFS_STAT, 0);
    // three zones, tops chained upward from zero
    for (int z = 0; z < 3; z++) begin
      wr(za(z, 0), 1000 * (z + 1));
      wr(za(z, 1), 100 * (z + 1));
      wr(za(z, 2), z + 1);
      wr(za(z, 5), z + 1);
      wr(za(z, 6), z + 1);
    end
    wr(za(0, 7), 32'h00640032);
    wr(za(2, 4), 32'h1388);
    wr(OFS_CTRL, 32'h33c);
    wr(OFS_SETP, 1500);
    zs(0, P_RST);
    wr(OFS_CTRL, 32'h33d);
    zs(2, 200);
    chk("relays", 2'b10, {relay_high_o, relay_low_o});
    chk("integ", 2, integ_o);
    chk("range", 2, heater_range_o);
    chk("scale", 1, man_scale_o);
    chk("tuning", 1, zone_tuning_o);
    wr(OFS_SETP, 1000);
    zs(1, 100);
    chk("aout", 32'h00640032, {aout2_o, aout1_o});
    wr(12'h044, 555);
    wr(OFS_SETP, 900);
    zs(1, 555);
    wr(OFS_SETP, 32'h00ffffff);
    zs(3, 300);
    chk("mout", 32'h1388, man_out_o);
    wr(OFS_CTRL, 32'h300);
    wr(OFS_SETP, 1500);
    zs(0, 300);
    chk("tuning", 0, zone_tuning_o);
    chk("relays", 0, {relay_high_o, relay_low_o});
    chk("aout", 0, {aout2_o, aout1_o});
    // second reset in mid-run brings back the reset values
    reset_i <= 1;
    tick(2);
    reset_i <= 0;
    tick(1);
    rd(12'h044, P_RST);
    rd(OFS_CTRL, 0);
    results();
  end
endmodule
bind zone_parameter_selector zone_sel_props #(.NZONES(NZONES)) u_zone_sel_props (
  .clk_sys_i(clk_sys_i),
  .reset_i(reset_i),
  .zone_tuning_o(zone_tuning_o),
  .relay_low_o(relay_low_o),
  .relay_low_zone_o(relay_low_zone_o),
  .active_zone_o(active_zone_o),
  .heater_range_o(heater_range_o),
  .man_scale_o(man_scale_o),
  .integ_o(integ_o),
  .man_out_o(man_out_o),
  .deriv_o(deriv_o),
  .aout1_o(aout1_o)
);

/* zone_pkg.sv */
/*
  Shared constants for the zone parameter selector: register map, field
  layouts, value limits, reset values, control modes and bus responses.
  Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
*/
// Behaviour
// - integral accepts 1..10000, zero turns it off
// - derivative accepts 1..2500, zero turns it off
// - manual output held as percent, 0..100
// - no power units for zone entries
// - manual output multiplier follows heater range only
// - heater range named by full-scale current
// - zone relay states drive relays only in zone mode
// - zone analog values apply only in zone mode
// - analog value bipolar -100..+100, unipolar 0..+100
// - used zones start at one, contiguous, ten max
// - table takes effect only in zone tuning mode
// - new zone on setpoint change loads its parameters
// - manual edits kept until setpoint leaves zone
// - setpoint above top zone uses the top zone
// - selecting closed-loop PID ends zone tuning
// - zone one starts at zero, tops chain contiguously
// - proportional accepts 0.001..1000
package zone_pkg;
  localparam int ZONES_MAX = 10; // table depth
  localparam int ADDR_W = 12; // byte address width
  localparam int ZIDX_W = 4; // zone number width, 0 = none
  localparam int SETP_W = 32; // setpoint in millikelvin
  localparam int P_W = 20; // proportional in thousandths
  localparam int I_W = 14; // integral, whole units
  localparam int D_W = 12; // derivative, whole units
  localparam int MOUT_W = 14; // manual output in hundredths of percent
  localparam int RNG_W = 4; // heater range code
  localparam int AO_W = 16; // signed analog value, hundredths of percent

  // register map
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000; // mode and configuration
  localparam logic [ADDR_W-1:0] OFS_SETP = 12'h004; // setpoint
  localparam logic [ADDR_W-1:0] OFS_STAT = 12'h008; // status, reject flag w1c
  localparam logic [6:0] BLK_ACT = 7'h02; // active settings block at 0x040
  localparam logic [6:0] BLK_ZONE0 = 7'h08; // zone table at 0x100, 0x20 each

  // field index within a block, address bits [4:2]
  localparam logic [2:0] F_TOP = 3'h0; // upper setpoint limit (zones only)
  localparam logic [2:0] F_P = 3'h1;
  localparam logic [2:0] F_I = 3'h2;
  localparam logic [2:0] F_D = 3'h3;
  localparam logic [2:0] F_MOUT = 3'h4;
  localparam logic [2:0] F_RNG = 3'h5;
  localparam logic [2:0] F_RLY = 3'h6; // bit0 low relay, bit1 high relay
  localparam logic [2:0] F_AO = 3'h7; // [15:0] output 1, [31:16] output 2

  // control register bits
  localparam int CB_MODE = 0; // two bits
  localparam int CB_ZCFG = 2; // four bits: low, high relay, ao1, ao2 zone mode
  localparam int CB_BIP = 6; // two bits: ao1, ao2 bipolar
  localparam int CB_CNT = 8; // four bits: zones in use
  // status register bits
  localparam int SB_ZONE = 0; // four bits: loaded zone
  localparam int SB_TUNING = 4;
  localparam int SB_REJECT = 5;

  // limits
  localparam logic [P_W-1:0] P_MIN = 20'h00001; // 0.001
  localparam logic [P_W-1:0] P_MAX = 20'hf4240; // 1000.000
  localparam logic [I_W-1:0] I_MAX = 14'h2710; // 10000
  localparam logic [D_W-1:0] D_MAX = 12'h9c4; // 2500
  localparam logic [MOUT_W-1:0] MOUT_MAX = 14'h2710; // 100.00 %
  localparam logic [RNG_W-1:0] RNG_MAX = 4'h8; // highest range code
  localparam logic signed [AO_W-1:0] AO_MAX = 16'sh2710; // 100.00 %

  // reset values
  localparam logic [P_W-1:0] P_RST = 20'h02710; // 10.000
  localparam logic [I_W-1:0] I_RST = 14'h0014; // 20

  // control modes as written to the control register
  localparam logic [1:0] MODE_PID = 2'h0;
  localparam logic [1:0] MODE_ZONE = 2'h1;
  localparam logic [1:0] MODE_OPEN = 2'h2;
  typedef enum logic [2:0] {
    ST_PID = 3'b001,
    ST_ZONE = 3'b010,
    ST_OPEN = 3'b100
  } ctl_state_t;

  typedef enum logic [2:0] {
    AK_NONE, AK_CTRL, AK_SETP, AK_STAT, AK_ACT, AK_ZONE
  } addr_kind_t;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

/* zone_sel_props.sv */
/* checker for the zone selector outputs.
   assumes it is bound into the selector from the bench top file */
`timescale 1ns/1ps
module zone_sel_props import zone_pkg::*; #(
  parameter int NZONES = 10
) (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_i, // async reset, active high
  input wire logic zone_tuning_o, // zone mode active
  input wire logic relay_low_o, // low relay drive
  input wire logic relay_low_zone_o, // low relay under zone control
  input wire logic [3:0] active_zone_o, // loaded zone
  input wire logic [3:0] heater_range_o, // range code
  input wire logic [3:0] man_scale_o, // derived multiplier
  input wire logic [13:0] integ_o, // active integral
  input wire logic [13:0] man_out_o, // active manual output
  input wire logic [11:0] deriv_o, // active derivative
  input wire logic [15:0] aout1_o // analog 1 drive
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_integ; integ_o <= I_MAX; endproperty
  a_integ: assert property (p_integ) else $error("integral over limit");
  property p_deriv; deriv_o <= D_MAX; endproperty
  a_deriv: assert property (p_deriv) else $error("derivative over limit");
  property p_mout; man_out_o <= MOUT_MAX; endproperty
  a_mout: assert property (p_mout) else $error("manual output over 100");
  // multiplier is never set on its own, only derived from the range
  property p_scale;
    man_scale_o == (heater_range_o == 0 ? 4'h0 : heater_range_o - 4'h1);
  endproperty
  a_scale: assert property (p_scale) else $error("scale not from range");
  property p_ao; $signed(aout1_o) <= AO_MAX && $signed(aout1_o) >= -AO_MAX; endproperty
  a_ao: assert property (p_ao) else $error("analog out of bounds");
  property p_zmax; active_zone_o <= NZONES; endproperty
  a_zmax: assert property (p_zmax) else $error("zone past table");
  // a load can only come from zone tuning
  property p_load; $changed(active_zone_o) && active_zone_o != 0 |-> zone_tuning_o; endproperty
  a_load: assert property (p_load) else $error("load outside zone mode");
  property p_pid; !zone_tuning_o [*2] |-> active_zone_o == 0; endproperty
  a_pid: assert property (p_pid) else $error("zone kept after exit");
  property p_relay; !relay_low_zone_o [*2] |-> !relay_low_o; endproperty
  a_relay: assert property (p_relay) else $error("relay driven off zone");
endmodule
